// [pbs_pkg.sv]
// Constants, types and register map of the port B direction and function selector.
// Assumes an APB master at 100 MHz and an area-0 bus width mode held steady around reset.
package pbs_pkg;
	localparam int PBS_AW = 12;
	localparam logic [11:0] PBS_OFS_DIR_HIGH = 12'h000;
	localparam logic [11:0] PBS_OFS_DIR_LOW = 12'h004;
	localparam logic [11:0] PBS_OFS_FSEL_ONE = 12'h008;
	localparam logic [11:0] PBS_OFS_FSEL_TOP = 12'h024;
	localparam int PBS_NFSEL = 8;
	localparam logic [15:0] PBS_DIR_RESET = 16'h0000;
	localparam logic [15:0] PBS_FSEL_MASK = 16'h3777;
	localparam logic [15:0] PBS_FSEL_ALL1 = 16'h1111;
	localparam logic [15:0] PBS_FSEL_ZERO = 16'h0000;
	localparam logic [1:0] PBS_MODE_32 = 2'h0;
	localparam logic [1:0] PBS_MODE_16 = 2'h1;
	localparam logic [1:0] PBS_MODE_8 = 2'h2;
	localparam int PBS_P31_LSB = 12;
	localparam int PBS_P30_LSB = 8;
	localparam int PBS_P29_LSB = 4;
	localparam int PBS_P28_LSB = 0;
	localparam logic [2:0] PBS_C_PORT = 3'h0;
	localparam logic [2:0] PBS_C_BUS = 3'h1;
	localparam logic [2:0] PBS_C_PINT = 3'h2;
	localparam logic [2:0] PBS_C_SER = 3'h3;
	localparam logic [2:0] PBS_C_TMR = 3'h4;

	typedef enum logic [2:0] {
		PBS_CLS_PORT,
		PBS_CLS_BUS,
		PBS_CLS_IN,
		PBS_CLS_OUT,
		PBS_CLS_IO,
		PBS_CLS_OFF
	} pbs_cls_e;

	// Value a function select takes on power-on reset or deep standby entry.
	function automatic logic [15:0] pbs_fsel_init(input logic [2:0] k, input logic [1:0] mode);
		logic [15:0] v;
		v = PBS_FSEL_ZERO;
		if (k < 3'h2)
		begin
			v = PBS_FSEL_ALL1;
		end
		else if (k < 3'h4)
		begin
			v = (mode == PBS_MODE_32 || mode == PBS_MODE_16) ? PBS_FSEL_ALL1 : PBS_FSEL_ZERO;
		end
		else
		begin
			v = (mode == PBS_MODE_32) ? PBS_FSEL_ALL1 : PBS_FSEL_ZERO;
		end
		return v;
	endfunction : pbs_fsel_init
endpackage : pbs_pkg

// [pbs_reg_if.sv]
// Decoded register access passed from the APB slave to the register file.
// Assumes one clock domain; carries no state.
`timescale 1ns/1ps
`default_nettype none
interface pbs_reg_if;
	logic wr_en;
	logic [3:0] idx;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport bus (output wr_en, output idx, output wdata, input rdata);
	modport regs (input wr_en, input idx, input wdata, output rdata);
endinterface : pbs_reg_if
`default_nettype wire

// [pbs_apb_slave.sv]
// APB slave front end: decodes word addresses and answers the bus.
// Assumes the register file behind it answers reads combinationally.
`timescale 1ns/1ps
`default_nettype none
module pbs_apb_slave
	import pbs_pkg::*;
(
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PBS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic stall,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	pbs_reg_if.bus rb
);
	logic mapped;
	logic access;

	assign mapped = (paddr <= PBS_OFS_FSEL_TOP) && (paddr[1:0] == 2'h0);
	assign access = psel && penable;
	assign pready = !stall;
	assign pslverr = access && !mapped;
	assign rb.idx = paddr[5:2];
	assign rb.wdata = pwdata[15:0];
	assign rb.wr_en = access && pwrite && mapped && pready;
	assign prdata = (access && !pwrite && mapped) ? {16'h0000, rb.rdata} : 32'h0000_0000;
endmodule : pbs_apb_slave
`default_nettype wire

// [pbs_pin_cell.sv]
// One pin's output and input steering for a given function class.
// Assumes the class and direction come from flip-flops in the register file.
`timescale 1ns/1ps
`default_nettype none
module pbs_pin_cell
	import pbs_pkg::*;
(
	input wire pbs_cls_e cls,
	input wire logic dir,
	input wire logic port_o,
	input wire logic bus_o,
	input wire logic bus_oe,
	input wire logic alt_o,
	input wire logic alt_oe,
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe,
	output logic bus_i,
	output logic alt_i
);
	always_comb
	begin
		pin_o = 1'b0;
		pin_oe = 1'b0;
		bus_i = 1'b0;
		alt_i = 1'b0;
		unique case (cls)
			PBS_CLS_PORT:
			begin
				pin_o = port_o;
				pin_oe = dir;
			end
			PBS_CLS_BUS:
			begin
				pin_o = bus_o;
				pin_oe = bus_oe;
				bus_i = pin_i;
			end
			PBS_CLS_IN:
			begin
				alt_i = pin_i;
			end
			PBS_CLS_OUT:
			begin
				pin_o = alt_o;
				pin_oe = 1'b1;
			end
			PBS_CLS_IO:
			begin
				pin_o = alt_o;
				pin_oe = alt_oe;
				alt_i = pin_i;
			end
			default:
			begin
				pin_oe = 1'b0;
			end
		endcase
	end
endmodule : pbs_pin_cell
`default_nettype wire

// [pbs_top.sv]
// Port B direction and function selector: registers, reset loading and pin routing.
// Assumes AREA0_MODE is stable at reset release and at deep standby entry.
`timescale 1ns/1ps
`default_nettype none
module pbs_top
	import pbs_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [PBS_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [1:0] AREA0_MODE,
	input wire logic DEEP_STANDBY_ENTRY,
	input wire logic [31:0] PIN_IN,
	output logic [31:0] PIN_OUT,
	output logic [31:0] PIN_OE,
	input wire logic [31:0] PORT_OUT,
	output logic [31:0] PORT_IN,
	input wire logic [31:0] DBUS_OUT,
	input wire logic DBUS_OE,
	output logic [31:0] DBUS_IN,
	input wire logic [27:0] ALT_OUT,
	input wire logic [27:0] ALT_OE,
	output logic [27:0] ALT_IN,
	output logic [3:0] PINT_A_IN,
	input wire logic SERIAL3_CLOCK_OUT,
	input wire logic SERIAL3_CLOCK_OE,
	output logic SERIAL3_CLOCK_IN,
	output logic SERIAL3_RECEIVE_IN,
	input wire logic SERIAL3_TRANSMIT_OUT,
	output logic TIMER0_CLOCK_IN,
	output logic TIMER0_RESET_IN,
	input wire logic TIMER0_COMPARE_OUT
);
	pbs_reg_if rb ();
	logic init_pending_reg;
	logic [15:0] dir_high_reg;
	logic [15:0] dir_low_reg;
	logic [15:0] fsel_reg [PBS_NFSEL];
	logic reload;
	logic [31:0] dir_all;
	pbs_cls_e cls [32];
	logic [31:0] alt_o;
	logic [31:0] alt_oe;
	logic [31:0] alt_i;
	logic [2:0] code31;
	logic [2:0] code30;
	logic [2:0] code29;
	logic [2:0] code28;

	////////////////////////////////////////////////////////////////////////////////////////
	// Bus front end. Accesses stall until the mode-dependent values are loaded after reset release; deep standby entry does not stall them.

	pbs_apb_slave u_apb (
		.psel(PSEL),
		.penable(PENABLE),
		.pwrite(PWRITE),
		.paddr(PADDR),
		.pwdata(PWDATA),
		.stall(init_pending_reg),
		.prdata(PRDATA),
		.pready(PREADY),
		.pslverr(PSLVERR),
		.rb(rb.bus)
	);

	////////////////////////////////////////////////////////////////////////////////////////
	// Reset loading. The asynchronous reset clears the registers and sets a flag; the mode-dependent values
	// are loaded by the first clock after release, as on deep standby entry.

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			init_pending_reg <= 1'b1;
		end
		else
		begin
			init_pending_reg <= 1'b0;
		end
	end

	assign reload = init_pending_reg || DEEP_STANDBY_ENTRY;

	////////////////////////////////////////////////////////////////////////////////////////
	// Direction registers. Deep standby entry also clears them.

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			dir_high_reg <= PBS_DIR_RESET;
		end
		else if (DEEP_STANDBY_ENTRY)
		begin
			dir_high_reg <= PBS_DIR_RESET;
		end
		else if (rb.wr_en && rb.idx == PBS_OFS_DIR_HIGH[5:2])
		begin
			dir_high_reg <= rb.wdata;
		end
	end

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			dir_low_reg <= PBS_DIR_RESET;
		end
		else if (DEEP_STANDBY_ENTRY)
		begin
			dir_low_reg <= PBS_DIR_RESET;
		end
		else if (rb.wr_en && rb.idx == PBS_OFS_DIR_LOW[5:2])
		begin
			dir_low_reg <= rb.wdata;
		end
	end

	assign dir_all = {dir_high_reg, dir_low_reg};

	////////////////////////////////////////////////////////////////////////////////////////
	// Function-select registers, one through the top one at consecutive words.

	for (genvar g = 0; g < PBS_NFSEL; g++)
	begin : g_fsel
		localparam logic [3:0] IDX = PBS_OFS_FSEL_ONE[5:2] + 4'(g);
		always_ff @(posedge CLK or negedge RST_B)
		begin
			if (!RST_B)
			begin
				fsel_reg[g] <= PBS_FSEL_ZERO;
			end
			else if (reload)
			begin
				fsel_reg[g] <= pbs_fsel_init(3'(g), AREA0_MODE);
			end
			else if (rb.wr_en && rb.idx == IDX)
			begin
				fsel_reg[g] <= rb.wdata & PBS_FSEL_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Read-back.

	always_comb
	begin
		rb.rdata = 16'h0000;
		if (rb.idx == PBS_OFS_DIR_HIGH[5:2])
		begin
			rb.rdata = dir_high_reg;
		end
		else if (rb.idx == PBS_OFS_DIR_LOW[5:2])
		begin
			rb.rdata = dir_low_reg;
		end
		else if (rb.idx <= PBS_OFS_FSEL_TOP[5:2])
		begin
			rb.rdata = fsel_reg[3'(rb.idx - PBS_OFS_FSEL_ONE[5:2])] & PBS_FSEL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Pin classes. Pins 27 to 0 use a generic decode; pins 31 to 28 the full one.

	assign code31 = {1'b0, fsel_reg[7][PBS_P31_LSB +: 2]};
	assign code30 = fsel_reg[7][PBS_P30_LSB +: 3];
	assign code29 = fsel_reg[7][PBS_P29_LSB +: 3];
	assign code28 = fsel_reg[7][PBS_P28_LSB +: 3];

	always_comb
	begin
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < 28; i++)
		begin
			c = fsel_reg[i / 4][(i % 4) * 4 +: 3];
			if (c == PBS_C_PORT)
			begin
				cls[i] = PBS_CLS_PORT;
			end
			else if (c == PBS_C_BUS)
			begin
				cls[i] = PBS_CLS_BUS;
			end
			else if (c <= PBS_C_TMR)
			begin
				cls[i] = PBS_CLS_IO;
			end
			else
			begin
				cls[i] = PBS_CLS_OFF;
			end
		end
		unique case (code31)
			PBS_C_PORT: cls[31] = PBS_CLS_PORT;
			PBS_C_BUS: cls[31] = PBS_CLS_BUS;
			PBS_C_PINT: cls[31] = PBS_CLS_IN;
			default: cls[31] = PBS_CLS_OFF;
		endcase
		unique case (code30)
			PBS_C_PORT: cls[30] = PBS_CLS_PORT;
			PBS_C_BUS: cls[30] = PBS_CLS_BUS;
			PBS_C_PINT: cls[30] = PBS_CLS_IN;
			PBS_C_SER: cls[30] = PBS_CLS_IO;
			PBS_C_TMR: cls[30] = PBS_CLS_IN;
			default: cls[30] = PBS_CLS_OFF;
		endcase
		unique case (code29)
			PBS_C_PORT: cls[29] = PBS_CLS_PORT;
			PBS_C_BUS: cls[29] = PBS_CLS_BUS;
			PBS_C_PINT: cls[29] = PBS_CLS_IN;
			PBS_C_SER: cls[29] = PBS_CLS_IN;
			PBS_C_TMR: cls[29] = PBS_CLS_IN;
			default: cls[29] = PBS_CLS_OFF;
		endcase
		unique case (code28)
			PBS_C_PORT: cls[28] = PBS_CLS_PORT;
			PBS_C_BUS: cls[28] = PBS_CLS_BUS;
			PBS_C_PINT: cls[28] = PBS_CLS_IN;
			PBS_C_SER: cls[28] = PBS_CLS_OUT;
			PBS_C_TMR: cls[28] = PBS_CLS_OUT;
			default: cls[28] = PBS_CLS_OFF;
		endcase
	end

	assign alt_o[27:0] = ALT_OUT;
	assign alt_oe[27:0] = ALT_OE;
	assign alt_o[28] = (code28 == PBS_C_SER) ? SERIAL3_TRANSMIT_OUT : TIMER0_COMPARE_OUT;
	assign alt_oe[28] = 1'b1;
	assign alt_o[29] = 1'b0;
	assign alt_oe[29] = 1'b0;
	assign alt_o[30] = SERIAL3_CLOCK_OUT;
	assign alt_oe[30] = SERIAL3_CLOCK_OE;
	assign alt_o[31] = 1'b0;
	assign alt_oe[31] = 1'b0;

	for (genvar p = 0; p < 32; p++)
	begin : g_pin
		pbs_pin_cell u_cell (
			.cls(cls[p]),
			.dir(dir_all[p]),
			.port_o(PORT_OUT[p]),
			.bus_o(DBUS_OUT[p]),
			.bus_oe(DBUS_OE),
			.alt_o(alt_o[p]),
			.alt_oe(alt_oe[p]),
			.pin_i(PIN_IN[p]),
			.pin_o(PIN_OUT[p]),
			.pin_oe(PIN_OE[p]),
			.bus_i(DBUS_IN[p]),
			.alt_i(alt_i[p])
		);
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Interrupt, serial and timer inputs see the pin only while their own code is selected; PORT_IN always sees it.

	assign PORT_IN = PIN_IN;
	assign ALT_IN = alt_i[27:0];
	assign PINT_A_IN[3] = alt_i[31] && (code31 == PBS_C_PINT);
	assign PINT_A_IN[2] = alt_i[30] && (code30 == PBS_C_PINT);
	assign PINT_A_IN[1] = alt_i[29] && (code29 == PBS_C_PINT);
	assign PINT_A_IN[0] = alt_i[28] && (code28 == PBS_C_PINT);
	assign SERIAL3_CLOCK_IN = alt_i[30] && (code30 == PBS_C_SER);
	assign TIMER0_CLOCK_IN = alt_i[30] && (code30 == PBS_C_TMR);
	assign SERIAL3_RECEIVE_IN = alt_i[29] && (code29 == PBS_C_SER);
	assign TIMER0_RESET_IN = alt_i[29] && (code29 == PBS_C_TMR);

	////////////////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_dstby_dir;
		@(posedge CLK) disable iff (!RST_B)
		DEEP_STANDBY_ENTRY |=> (dir_high_reg == PBS_DIR_RESET) && (dir_low_reg == PBS_DIR_RESET);
	endproperty
	a_dstby_dir: assert property (p_dstby_dir) else $error("direction not cleared");

	property p_dir_write;
		@(posedge CLK) disable iff (!RST_B)
		(rb.wr_en && rb.idx == PBS_OFS_DIR_HIGH[5:2] && !DEEP_STANDBY_ENTRY)
			|=> dir_high_reg == $past(rb.wdata);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write lost");

	property p_dir_hold;
		@(posedge CLK) disable iff (!RST_B)
		(!rb.wr_en && !reload)[*2] |-> $stable(dir_low_reg) && $stable(fsel_reg[7]);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("register changed unasked");

	property p_low_init;
		@(posedge CLK) disable iff (!RST_B)
		$fell(init_pending_reg) |-> fsel_reg[0] == PBS_FSEL_ALL1 && fsel_reg[1] == PBS_FSEL_ALL1;
	endproperty
	a_low_init: assert property (p_low_init) else $error("low selects not loaded");

	property p_mode8;
		@(posedge CLK) disable iff (!RST_B)
		(DEEP_STANDBY_ENTRY && AREA0_MODE == PBS_MODE_8)
			|=> fsel_reg[2] == PBS_FSEL_ZERO && fsel_reg[7] == PBS_FSEL_ZERO;
	endproperty
	a_mode8: assert property (p_mode8) else $error("8-bit mode load wrong");

	property p_mode32;
		@(posedge CLK) disable iff (!RST_B)
		(DEEP_STANDBY_ENTRY && AREA0_MODE == PBS_MODE_32) |=> code31 == {2'h0, PBS_C_BUS[0]}
			&& code28 == PBS_C_BUS;
	endproperty
	a_mode32: assert property (p_mode32) else $error("top fields not on bus code");

	property p_pin0_out;
		@(posedge CLK) disable iff (!RST_B)
		(fsel_reg[0][2:0] == PBS_C_PORT && dir_low_reg[0]) |-> PIN_OE[0] && PIN_OUT[0] == PORT_OUT[0];
	endproperty
	a_pin0_out: assert property (p_pin0_out) else $error("port output not driven");

	property p_dir_ignored;
		@(posedge CLK) disable iff (!RST_B)
		(code31 == PBS_C_PINT && dir_high_reg[15]) |-> !PIN_OE[31] && PINT_A_IN[3] == PIN_IN[31];
	endproperty
	a_dir_ignored: assert property (p_dir_ignored) else $error("direction not ignored");

	property p_pin30_clk;
		@(posedge CLK) disable iff (!RST_B)
		code30 == PBS_C_SER |-> PIN_OE[30] == SERIAL3_CLOCK_OE && SERIAL3_CLOCK_IN == PIN_IN[30];
	endproperty
	a_pin30_clk: assert property (p_pin30_clk) else $error("serial clock misrouted");

	property p_pin29_tmr;
		@(posedge CLK) disable iff (!RST_B)
		code29 == PBS_C_TMR |-> !PIN_OE[29] && TIMER0_RESET_IN == PIN_IN[29] && !SERIAL3_RECEIVE_IN;
	endproperty
	a_pin29_tmr: assert property (p_pin29_tmr) else $error("timer reset misrouted");

	property p_pin28_tx;
		@(posedge CLK) disable iff (!RST_B)
		code28 == PBS_C_SER |-> PIN_OE[28] && PIN_OUT[28] == SERIAL3_TRANSMIT_OUT;
	endproperty
	a_pin28_tx: assert property (p_pin28_tx) else $error("transmit misrouted");

	property p_resv_read;
		@(posedge CLK) disable iff (!RST_B)
		(PSEL && PENABLE && !PWRITE && PREADY && PADDR == PBS_OFS_FSEL_TOP)
			|-> (PRDATA[15:0] & ~PBS_FSEL_MASK) == 16'h0000 && PRDATA[31:16] == 16'h0000;
	endproperty
	a_resv_read: assert property (p_resv_read) else $error("reserved bits read set");

	property p_prohib;
		@(posedge CLK) disable iff (!RST_B)
		code30 > PBS_C_TMR |-> !PIN_OE[30] && !TIMER0_CLOCK_IN && !SERIAL3_CLOCK_IN;
	endproperty
	a_prohib: assert property (p_prohib) else $error("prohibited code drives pin");
endmodule : pbs_top
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the port B direction and function selector.
// Assumes the package, the register interface and the selector modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pbs_pkg::*;
;
	logic clk, rst_b, psel, penable, pwrite, deep, dbus_oe, s3c_out, s3c_oe, s3t_out, t0c_out;
	logic pready, pslverr, s3c_in, s3r_in, t0c_in, t0r_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, port_out, port_in, dbus_out, dbus_in;
	logic [1:0] mode;
	logic [3:0] pint;
	logic [27:0] alt_in;
	int err_count, cmp_count;

	pbs_top pbs_top_i (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .AREA0_MODE(mode), .DEEP_STANDBY_ENTRY(deep), .PIN_IN(pin_in),
		.PIN_OUT(pin_out), .PIN_OE(pin_oe), .PORT_OUT(port_out), .PORT_IN(port_in),
		.DBUS_OUT(dbus_out), .DBUS_OE(dbus_oe), .DBUS_IN(dbus_in), .ALT_OUT(~port_out[27:0]),
		.ALT_OE(28'hfff_ffff), .ALT_IN(alt_in), .PINT_A_IN(pint), .SERIAL3_CLOCK_OUT(s3c_out),
		.SERIAL3_CLOCK_OE(s3c_oe), .SERIAL3_CLOCK_IN(s3c_in), .SERIAL3_RECEIVE_IN(s3r_in),
		.SERIAL3_TRANSMIT_OUT(s3t_out), .TIMER0_CLOCK_IN(t0c_in), .TIMER0_RESET_IN(t0r_in),
		.TIMER0_COMPARE_OUT(t0c_out));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One APB transfer; read data and error are taken at the edge that completes it.
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
		output logic [31:0] rd, output logic se);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				err_count++;
				wrap_up();
			end
			@(posedge clk);
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] r;
		logic s;
		apb(1'b1, a, d, r, s);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [15:0] e);
		logic [31:0] r;
		logic s;
		apb(1'b0, a, 16'h0000, r, s);
		chk($sformatf("reg %h", a), r, {16'h0000, e});
		chk("slverr", {31'h0, s}, 32'h0);
	endtask : rdc

	function automatic logic [11:0] sel_a(int k);
		return PBS_OFS_FSEL_ONE + 12'(4 * (k - 1));
	endfunction : sel_a

	function automatic logic [15:0] exp_sel(int k, logic [1:0] m);
		if (k <= 2)
			return 16'h1111;
		if (k <= 4)
			return (m == PBS_MODE_32 || m == PBS_MODE_16) ? 16'h1111 : 16'h0000;
		return (m == PBS_MODE_32) ? 16'h1111 : 16'h0000;
	endfunction : exp_sel

	// Expected drive enable and value of a top pin, given a direction bit of 1.
	function automatic logic [1:0] exp_pin(int j, logic [2:0] f);
		if (f == PBS_C_PORT)
			return {1'b1, port_out[j]};
		if (f == PBS_C_BUS)
			return {dbus_oe, dbus_out[j]};
		if (j == 30 && f == PBS_C_SER)
			return {s3c_oe, s3c_out};
		if (j == 28 && f == PBS_C_SER)
			return {1'b1, s3t_out};
		if (j == 28 && f == PBS_C_TMR)
			return {1'b1, t0c_out};
		return 2'b00;
	endfunction : exp_pin

////////////////////////////////////////////////////////////////////////////////
	task automatic do_reset(input logic [1:0] m);
		@(posedge clk);
		rst_b <= 1'b0;
		mode <= m;
		dbus_oe <= 1'b0;
		repeat (16) @(posedge clk);
		chk("pin_oe in reset", pin_oe, 32'h0);
		rst_b <= 1'b1;
	endtask : do_reset

	task automatic check_all(input logic [1:0] m);
		rdc(PBS_OFS_DIR_HIGH, PBS_DIR_RESET);
		rdc(PBS_OFS_DIR_LOW, PBS_DIR_RESET);
		for (int k = 1; k <= 8; k++)
			rdc(sel_a(k), exp_sel(k, m));
		@(negedge clk);
		chk("pin_oe", pin_oe, 32'h0);
	endtask : check_all

	task automatic t_dir;
		for (int k = 1; k <= 8; k++)
			wr(sel_a(k), 16'h0000);
		wr(PBS_OFS_DIR_HIGH, 16'ha5c3);
		wr(PBS_OFS_DIR_LOW, 16'h5a3c);
		@(negedge clk);
		chk("pin_oe", pin_oe, 32'ha5c35a3c);
		chk("pin_out", pin_out & pin_oe, port_out & 32'ha5c35a3c);
		chk("port_in", port_in, pin_in);
		rdc(PBS_OFS_DIR_HIGH, 16'ha5c3);
		rdc(PBS_OFS_DIR_LOW, 16'h5a3c);
	endtask : t_dir

	// Pins 3..2 have direction 1, pins 1..0 direction 0; the alternate function or bus owns
	// the enable of all four.
	task automatic t_ignore;
		wr(sel_a(1), 16'h3333);
		@(negedge clk);
		chk("pin_oe alt", {28'h0, pin_oe[3:0]}, 32'hf);
		chk("pin_out alt", {28'h0, pin_out[3:0]}, {28'h0, ~port_out[3:0]});
		chk("alt_in", {28'h0, alt_in[3:0]}, {28'h0, pin_in[3:0]});
		wr(sel_a(1), 16'h1111);
		@(negedge clk);
		chk("pin_oe bus off", {28'h0, pin_oe[3:0]}, 32'h0);
		@(posedge clk);
		dbus_oe <= 1'b1;
		@(negedge clk);
		chk("pin_oe bus on", {28'h0, pin_oe[3:0]}, 32'hf);
		chk("pin_out bus", {28'h0, pin_out[3:0]}, {28'h0, dbus_out[3:0]});
		chk("dbus_in", {28'h0, dbus_in[3:0]}, {28'h0, pin_in[3:0]});
	endtask : t_ignore

	task automatic t_reserved;
		logic [31:0] r;
		logic s;
		for (int k = 1; k <= 8; k++)
		begin
			wr(sel_a(k), 16'hffff);
			rdc(sel_a(k), PBS_FSEL_MASK);
		end
		apb(1'b0, 12'h028, 16'h0000, r, s);
		chk("unmapped read", {s, r[30:0]}, 32'h80000000);
		apb(1'b1, 12'h002, 16'h1234, r, s);
		chk("unaligned write", {31'h0, s}, 32'h1);
	endtask : t_reserved

	task automatic t_top;
		logic [15:0] v;
		logic [2:0] f;
		logic [1:0] e;
		wr(PBS_OFS_DIR_HIGH, 16'hf000);
		for (int c = 0; c < 8; c++)
		begin
			v = {2'b00, 2'(c), 1'b0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)};
			wr(PBS_OFS_FSEL_TOP, v);
			rdc(PBS_OFS_FSEL_TOP, v);
			for (int p = 0; p < 2; p++)
			begin
				@(posedge clk);
				pin_in <= (p == 0) ? 32'ha0000000 : 32'h50000000;
				@(negedge clk);
				for (int j = 28; j < 32; j++)
				begin
					f = (j == 31) ? {1'b0, 2'(c)} : 3'(c);
					e = exp_pin(j, f);
					chk("top oe", {31'h0, pin_oe[j]}, {31'h0, e[1]});
					if (e[1] === 1'b1)
						chk("top out", {31'h0, pin_out[j]}, {31'h0, e[0]});
					chk("pint", {31'h0, pint[j - 28]}, {31'h0, (f == PBS_C_PINT) & pin_in[j]});
				end
				if (c == 3)
					chk("serial in", {30'h0, s3c_in, s3r_in}, {30'h0, pin_in[30:29]});
				if (c == 4)
					chk("timer in", {30'h0, t0c_in, t0r_in}, {30'h0, pin_in[30:29]});
			end
		end
	endtask : t_top

	task automatic t_deep;
		for (int m = 0; m < 3; m++)
		begin
			@(posedge clk);
			mode <= 2'(m);
			dbus_oe <= 1'b0;
			wr(PBS_OFS_DIR_LOW, 16'hffff);
			wr(sel_a(5), 16'h0222);
			@(posedge clk);
			deep <= 1'b1;
			@(posedge clk);
			deep <= 1'b0;
			check_all(2'(m));
		end
	endtask : t_deep

////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		err_count = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		{psel, penable, pwrite, deep, dbus_oe} = 5'h00;
		{s3c_out, s3c_oe, s3t_out, t0c_out} = 4'b1110;
		paddr = 12'h000;
		pwdata = 32'h0;
		mode = PBS_MODE_32;
		pin_in = 32'h6c39_a5f2;
		port_out = 32'h9f06_c3a5;
		dbus_out = 32'h5ac3_3c96;
		do_reset(PBS_MODE_32);
		check_all(PBS_MODE_32);
		t_dir();
		t_ignore();
		t_reserved();
		t_top();
		t_deep();
		do_reset(PBS_MODE_8);
		check_all(PBS_MODE_8);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
